// *** rtl/udie_pkg.sv ***
// package: register map, field positions and reset values of the
// device controller interrupt and endpoint control slice.
// assumes an 8-bit special function register port on page 1.
package udie_pkg;

    localparam logic [7:0] SFR_PAGE = 8'h01;
    localparam logic [7:0] OUT_EMPTY_EP1_BUFFER_CTRL_ADDR = 8'h9A;
    localparam logic [7:0] IN_FULL_EP2_BUFFER_CTRL_ADDR = 8'h9B;
    localparam logic [7:0] OUT_FULL_EP3_BUFFER_CTRL_ADDR = 8'h9C;
    localparam logic [7:0] TRANSFER_IRQ_ENABLE_LOW_ADDR = 8'hB6;
    localparam logic [7:0] TRANSFER_IRQ_ENABLE_HIGH_ADDR = 8'hB7;
    localparam logic [7:0] BUS_EVENT_STATUS_ADDR = 8'hB9;
    localparam logic [7:0] TRANSFER_STATUS_LOW_ADDR = 8'hBA;
    localparam logic [7:0] TRANSFER_STATUS_HIGH_ADDR = 8'hBB;
    localparam logic [7:0] ENDPOINT_ENABLE_STALL_ADDR = 8'hBC;
    localparam logic [7:0] EP0_BUFFER_CTRL_ADDR = 8'hBD;
    localparam logic [7:0] ZERO_PACKET_EP4_BUFFER_CTRL_ADDR = 8'hBE;

    localparam logic [7:0] TRANSFER_IRQ_ENABLE_LOW_RESET = 8'h03;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] BUS_EVENT_VALID_MASK = 8'hFB;
    localparam logic [7:0] TRANSFER_HIGH_ENABLE_MASK = 8'hFD;
    localparam logic [3:0] TRANSFER_HIGH_RW_MASK = 4'hD;

    localparam int DATA_READY_BIT = 1;
    localparam int BUFFER_FLUSH_BIT = 0;
    localparam int STATUS_FIELD_LSB = 3;
    localparam int ZLP_FIELD_LSB = 4;

    typedef enum logic [1:0] {
        UDIE_HOST_IDLE = 2'b00,
        UDIE_HOST_WRITE = 2'b01,
        UDIE_HOST_READ = 2'b10
    } udie_host_state_type;

endpackage

// *** rtl/udie_sfr_if.sv ***
// interface: special function register port between cpu side and slice.
// assumes a single clock; reads answer combinationally in the same cycle.
`timescale 1ns/10ps
interface udie_sfr_if (
    input wire logic ref_clk_in,
    input wire logic nrst_in
);
    logic [7:0] addr;
    logic [7:0] page;
    logic wr_en;
    logic rd_en;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic irq;

    modport device (
        input ref_clk_in, nrst_in, addr, page, wr_en, rd_en, wdata,
        output rdata, irq
    );
    modport host (
        input ref_clk_in, nrst_in, rdata, irq,
        output addr, page, wr_en, rd_en, wdata
    );
endinterface

// *** rtl/udie_host_port.sv ***
// host end: turns one-cycle user requests into register port accesses.
// assumes the user waits for done before the next request.
`timescale 1ns/10ps
module udie_host_port
    import udie_pkg::*;
(
    udie_sfr_if.host sfr,
    input wire logic req_in,
    input wire logic req_write_in,
    input wire logic [7:0] req_addr_in,
    input wire logic [7:0] req_wdata_in,
    output logic busy_out,
    output logic done_out,
    output logic [7:0] rdata_out,
    output logic irq_out
);
    udie_host_state_type state_r;
    logic [7:0] addr_r;
    logic [7:0] wdata_r;

    // ***************************
    // request capture
    // ***************************
    always_ff @(posedge sfr.ref_clk_in or negedge sfr.nrst_in) begin
        if (!sfr.nrst_in) begin
            state_r <= UDIE_HOST_IDLE;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
        end else begin
            case (state_r)
                UDIE_HOST_IDLE: begin
                    if (req_in) begin
                        addr_r <= req_addr_in;
                        wdata_r <= req_wdata_in;
                        state_r <= req_write_in ? UDIE_HOST_WRITE : UDIE_HOST_READ;
                    end
                end
                default: begin
                    state_r <= UDIE_HOST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sfr.ref_clk_in or negedge sfr.nrst_in) begin
        if (!sfr.nrst_in) begin
            rdata_out <= 8'h00;
            done_out <= 1'b0;
        end else begin
            done_out <= (state_r != UDIE_HOST_IDLE);
            if (state_r == UDIE_HOST_READ) begin
                rdata_out <= sfr.rdata;
            end
        end
    end

    // ***************************
    // port drive
    // ***************************
    // every access targets page 1; the slice ignores other pages
    assign sfr.page = SFR_PAGE;
    assign sfr.addr = addr_r;
    assign sfr.wdata = wdata_r;
    assign sfr.wr_en = (state_r == UDIE_HOST_WRITE);
    assign sfr.rd_en = (state_r == UDIE_HOST_READ);
    assign busy_out = (state_r != UDIE_HOST_IDLE);
    assign irq_out = sfr.irq;
endmodule

// *** rtl/udie_device_slice.sv ***
// device end: interrupt enables, status flags and endpoint buffer control.
// assumes event pulses and buffer levels come from the transfer engine,
// synchronous to ref_clk_in.
`timescale 1ns/10ps
module udie_device_slice
    import udie_pkg::*;
(
    udie_sfr_if.device sfr,
    input wire logic [7:0] bus_event_in,
    input wire logic [7:0] xfer_low_done_in,
    input wire logic [1:0] ep4_done_in,
    input wire logic transition_error_in,
    input wire logic [4:0] in_empty_in,
    input wire logic [4:0] out_empty_in,
    input wire logic [4:0] in_full_in,
    input wire logic [4:0] out_full_in,
    input wire logic [4:0] buffer_drained_in,
    input wire logic [4:1] zero_packet_sent_in,
    output logic [4:1] ep_halt_out,
    output logic [4:1] ep_active_out,
    output logic [4:0] data_ready_out,
    output logic [4:0] buffer_flush_out,
    output logic [4:1] zero_packet_req_out
);
    logic [7:0] irq_en_low_r;
    logic [7:0] irq_en_high_r;
    logic [7:0] bus_status_r;
    logic [7:0] xfer_status_low_r;
    logic [3:0] xfer_status_high_r;
    logic [7:0] ep_ctrl_r;
    logic [4:0] data_ready_r;
    logic [4:0] flush_r;
    logic [4:1] zlp_r;
    logic [7:0] status_high_view;
    logic [7:0] rdata_nxt;
    logic sel;

    // plain address match, qualified by page
    function automatic logic hit(input logic [7:0] a, input logic [7:0] p, input logic [7:0] ref_a);
        hit = (p == SFR_PAGE) && (a == ref_a);
    endfunction

    assign sel = sfr.wr_en && (sfr.page == SFR_PAGE);

    // ***************************
    // enable and control registers
    // ***************************
    always_ff @(posedge sfr.ref_clk_in or negedge sfr.nrst_in) begin
        if (!sfr.nrst_in) begin
            irq_en_low_r <= TRANSFER_IRQ_ENABLE_LOW_RESET;
            irq_en_high_r <= REG_RESET;
            ep_ctrl_r <= REG_RESET;
        end else if (sel) begin
            if (sfr.addr == TRANSFER_IRQ_ENABLE_LOW_ADDR) begin
                irq_en_low_r <= sfr.wdata;
            end else if (sfr.addr == TRANSFER_IRQ_ENABLE_HIGH_ADDR) begin
                irq_en_high_r <= sfr.wdata & TRANSFER_HIGH_ENABLE_MASK;
            end else if (sfr.addr == ENDPOINT_ENABLE_STALL_ADDR) begin
                ep_ctrl_r <= sfr.wdata;
            end
        end
    end

    // ***************************
    // sticky status flags
    // ***************************
    // a write of 0 clears a flag; an event in the same cycle wins
    always_ff @(posedge sfr.ref_clk_in or negedge sfr.nrst_in) begin
        if (!sfr.nrst_in) begin
            bus_status_r <= REG_RESET;
        end else if (sel && sfr.addr == BUS_EVENT_STATUS_ADDR) begin
            bus_status_r <= ((bus_status_r & sfr.wdata) | bus_event_in) & BUS_EVENT_VALID_MASK;
        end else begin
            bus_status_r <= (bus_status_r | bus_event_in) & BUS_EVENT_VALID_MASK;
        end
    end

    always_ff @(posedge sfr.ref_clk_in or negedge sfr.nrst_in) begin
        if (!sfr.nrst_in) begin
            xfer_status_low_r <= REG_RESET;
        end else if (sel && sfr.addr == TRANSFER_STATUS_LOW_ADDR) begin
            xfer_status_low_r <= (xfer_status_low_r & sfr.wdata) | xfer_low_done_in;
        end else begin
            xfer_status_low_r <= xfer_status_low_r | xfer_low_done_in;
        end
    end

    // bits 3..0 of the high status: ep4 out, ep4 in, reserved, error
    always_ff @(posedge sfr.ref_clk_in or negedge sfr.nrst_in) begin
        if (!sfr.nrst_in) begin
            xfer_status_high_r <= 4'h0;
        end else if (sel && sfr.addr == TRANSFER_STATUS_HIGH_ADDR) begin
            xfer_status_high_r <= ((xfer_status_high_r & sfr.wdata[3:0])
                | {ep4_done_in, 1'b0, transition_error_in}) & TRANSFER_HIGH_RW_MASK;
        end else begin
            xfer_status_high_r <= (xfer_status_high_r
                | {ep4_done_in, 1'b0, transition_error_in}) & TRANSFER_HIGH_RW_MASK;
        end
    end

    // ***************************
    // endpoint buffer control
    // ***************************
    // data-ready: firmware sets, drained buffer clears; drain wins
    // flush: level held until firmware writes it low
    generate
        for (genvar ep = 0; ep < 5; ep++) begin : g_buf
            localparam logic [7:0] ADDR = (ep == 0) ? EP0_BUFFER_CTRL_ADDR :
                (ep == 1) ? OUT_EMPTY_EP1_BUFFER_CTRL_ADDR :
                (ep == 2) ? IN_FULL_EP2_BUFFER_CTRL_ADDR :
                (ep == 3) ? OUT_FULL_EP3_BUFFER_CTRL_ADDR : ZERO_PACKET_EP4_BUFFER_CTRL_ADDR;
            always_ff @(posedge sfr.ref_clk_in or negedge sfr.nrst_in) begin
                if (!sfr.nrst_in) begin
                    data_ready_r[ep] <= 1'b0;
                    flush_r[ep] <= 1'b0;
                end else begin
                    if (buffer_drained_in[ep]) begin
                        data_ready_r[ep] <= 1'b0;
                    end else if (sel && sfr.addr == ADDR) begin
                        data_ready_r[ep] <= sfr.wdata[DATA_READY_BIT];
                    end
                    if (sel && sfr.addr == ADDR) begin
                        flush_r[ep] <= sfr.wdata[BUFFER_FLUSH_BIT];
                    end
                end
            end
        end
        for (genvar z = 1; z < 5; z++) begin : g_zlp
            always_ff @(posedge sfr.ref_clk_in or negedge sfr.nrst_in) begin
                if (!sfr.nrst_in) begin
                    zlp_r[z] <= 1'b0;
                end else if (zero_packet_sent_in[z]) begin
                    zlp_r[z] <= 1'b0;
                end else if (sel && sfr.addr == ZERO_PACKET_EP4_BUFFER_CTRL_ADDR) begin
                    zlp_r[z] <= sfr.wdata[ZLP_FIELD_LSB + z - 1];
                end
            end
        end
    endgenerate

    // ***************************
    // outputs and read mux
    // ***************************
    assign ep_active_out = ep_ctrl_r[3:0];
    // stall only reaches the link for an enabled endpoint
    assign ep_halt_out = ep_ctrl_r[7:4] & ep_ctrl_r[3:0];
    assign data_ready_out = data_ready_r;
    assign buffer_flush_out = flush_r;
    assign zero_packet_req_out = zlp_r;
    assign status_high_view = {in_empty_in[4:1], xfer_status_high_r};

    always_comb begin
        rdata_nxt = 8'h00;
        if (hit(sfr.addr, sfr.page, TRANSFER_IRQ_ENABLE_LOW_ADDR)) begin
            rdata_nxt = irq_en_low_r;
        end else if (hit(sfr.addr, sfr.page, TRANSFER_IRQ_ENABLE_HIGH_ADDR)) begin
            rdata_nxt = irq_en_high_r;
        end else if (hit(sfr.addr, sfr.page, BUS_EVENT_STATUS_ADDR)) begin
            rdata_nxt = bus_status_r;
        end else if (hit(sfr.addr, sfr.page, TRANSFER_STATUS_LOW_ADDR)) begin
            rdata_nxt = xfer_status_low_r;
        end else if (hit(sfr.addr, sfr.page, TRANSFER_STATUS_HIGH_ADDR)) begin
            rdata_nxt = status_high_view;
        end else if (hit(sfr.addr, sfr.page, ENDPOINT_ENABLE_STALL_ADDR)) begin
            rdata_nxt = ep_ctrl_r;
        end else if (hit(sfr.addr, sfr.page, EP0_BUFFER_CTRL_ADDR)) begin
            rdata_nxt = {6'h00, data_ready_r[0], flush_r[0]};
        end else if (hit(sfr.addr, sfr.page, ZERO_PACKET_EP4_BUFFER_CTRL_ADDR)) begin
            rdata_nxt = {zlp_r, 2'b00, data_ready_r[4], flush_r[4]};
        end else if (hit(sfr.addr, sfr.page, OUT_EMPTY_EP1_BUFFER_CTRL_ADDR)) begin
            rdata_nxt = {out_empty_in, 1'b0, data_ready_r[1], flush_r[1]};
        end else if (hit(sfr.addr, sfr.page, IN_FULL_EP2_BUFFER_CTRL_ADDR)) begin
            rdata_nxt = {in_full_in, 1'b0, data_ready_r[2], flush_r[2]};
        end else if (hit(sfr.addr, sfr.page, OUT_FULL_EP3_BUFFER_CTRL_ADDR)) begin
            rdata_nxt = {out_full_in, 1'b0, data_ready_r[3], flush_r[3]};
        end
    end

    assign sfr.rdata = rdata_nxt;
    // bus event flags have no enable in this slice; they drive irq directly
    assign sfr.irq = (|bus_status_r) | (|(xfer_status_low_r & irq_en_low_r))
        | (|(status_high_view & irq_en_high_r));
endmodule

// *** sim/udie_sfr_chk.sv ***
// checker: register port relations between host end and slice.
// assumes it sits beside the interface in the bench top.
`timescale 1ns/10ps
module udie_sfr_chk (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] addr,
    input wire logic [7:0] page,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic irq
);
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);
    // ****************************************
    // properties
    // ****************************************
    property p_unmapped;
        rd_en && !(addr inside {8'h9A, 8'h9B, 8'h9C, [8'hB6:8'hB7], [8'hB9:8'hBE]}) |-> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_en_low;
        wr_en && page == 8'h01 && addr == 8'hB6 ##1 page == 8'h01 && addr == 8'hB6 |-> rdata == $past(wdata);
    endproperty
    a_en_low: assert property (p_en_low) else $error("low enable readback");
    property p_en_high;
        wr_en && page == 8'h01 && addr == 8'hB7 ##1 page == 8'h01 && addr == 8'hB7 |-> rdata == ($past(wdata) & 8'hFD);
    endproperty
    a_en_high: assert property (p_en_high) else $error("high enable readback");
    property p_ctrl;
        wr_en && page == 8'h01 && addr == 8'hBC ##1 page == 8'h01 && addr == 8'hBC |-> rdata == $past(wdata);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("endpoint control readback");
    property p_bus_rsv;
        page == 8'h01 && addr == 8'hB9 |-> !rdata[2];
    endproperty
    a_bus_rsv: assert property (p_bus_rsv) else $error("bus status bit 2 set");
    property p_ep0_rsv;
        page == 8'h01 && addr == 8'hBD |-> rdata[7:2] == 6'h00;
    endproperty
    a_ep0_rsv: assert property (p_ep0_rsv) else $error("ep0 control upper bits set");
    property p_buf_rsv;
        page == 8'h01 && addr inside {8'h9A, 8'h9B, 8'h9C} |-> !rdata[2];
    endproperty
    a_buf_rsv: assert property (p_buf_rsv) else $error("buffer control bit 2 set");
    property p_irq;
        rd_en && page == 8'h01 && addr == 8'hB9 && rdata != 8'h00 |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("bus flag set without irq");
endmodule

// *** sim/tb.sv ***
// testbench: host end and slice joined by the register port.
// assumes the rtl package, interface and both ends compiled first.
`timescale 1ns/10ps
module tb;
    import udie_pkg::*;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic req_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [7:0] req_addr_in = 8'h00;
    logic [7:0] req_wdata_in = 8'h00;
    logic busy_out, done_out, irq_out;
    logic [7:0] rdata_out;
    logic [7:0] bev = 8'h00, xdone = 8'h00;
    logic [1:0] ep4d = 2'b00;
    logic terr = 1'b0;
    logic [4:0] in_empty = 5'h00, out_empty = 5'h00, in_full = 5'h00, out_full = 5'h00, drained = 5'h00;
    logic [4:1] zsent = 4'h0, halt, active, zreq;
    logic [4:0] dready, flush;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] map_a [11] = '{8'h9A, 8'h9B, 8'h9C, 8'hB6, 8'hB7, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE};
    // ****************************************
    // clock, reset, instances
    // ****************************************
    initial begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    udie_sfr_if sfr_bus (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in));
    udie_host_port u_udie_host_port (.sfr(sfr_bus), .req_in(req_in), .req_write_in(req_write_in),
        .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .busy_out(busy_out), .done_out(done_out),
        .rdata_out(rdata_out), .irq_out(irq_out));
    udie_device_slice u_udie_device_slice (.sfr(sfr_bus), .bus_event_in(bev), .xfer_low_done_in(xdone),
        .ep4_done_in(ep4d), .transition_error_in(terr), .in_empty_in(in_empty), .out_empty_in(out_empty),
        .in_full_in(in_full), .out_full_in(out_full), .buffer_drained_in(drained), .zero_packet_sent_in(zsent),
        .ep_halt_out(halt), .ep_active_out(active), .data_ready_out(dready), .buffer_flush_out(flush),
        .zero_packet_req_out(zreq));
    udie_sfr_chk u_chk (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .addr(sfr_bus.addr), .page(sfr_bus.page),
        .wr_en(sfr_bus.wr_en), .rd_en(sfr_bus.rd_en), .wdata(sfr_bus.wdata), .rdata(sfr_bus.rdata),
        .irq(sfr_bus.irq));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge ref_clk_in);
        req_in <= 1'b1;
        req_write_in <= wr;
        req_addr_in <= a;
        req_wdata_in <= d;
        @(posedge ref_clk_in);
        req_in <= 1'b0;
        @(negedge ref_clk_in);
        chk(8'h01, {7'h00, busy_out});
        for (i = 0; i < 6 && done_out !== 1'b1; i++) begin
            @(negedge ref_clk_in);
        end
        chk(8'h01, {7'h00, done_out});
        chk(8'h00, {7'h00, busy_out});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(exp, rdata_out);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // hang guard; whole run is under two hundred cycles
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (3) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        foreach (map_a[i]) begin
            rd(map_a[i], map_a[i] == TRANSFER_IRQ_ENABLE_LOW_ADDR ? TRANSFER_IRQ_ENABLE_LOW_RESET : REG_RESET);
        end
        rd(8'hB8, 8'h00);
        $display("test reset done");
        acc(1'b1, 8'hB6, 8'hFF);
        rd(8'hB6, 8'hFF);
        acc(1'b1, 8'hB7, 8'hFF);
        rd(8'hB7, 8'hFD);
        acc(1'b1, 8'hBC, 8'hA5);
        rd(8'hBC, 8'hA5);
        chk(8'h05, {4'h0, active});
        chk(8'h00, {4'h0, halt});
        acc(1'b1, 8'hBC, 8'hFF);
        chk(8'h0F, {4'h0, halt});
        $display("test enables done");
        @(posedge ref_clk_in);
        bev <= 8'hFF;
        @(posedge ref_clk_in);
        bev <= 8'h00;
        rd(8'hB9, 8'hFB);
        chk(8'h01, {7'h00, irq_out});
        acc(1'b1, 8'hB9, 8'h00);
        rd(8'hB9, 8'h00);
        chk(8'h00, {7'h00, irq_out});
        @(posedge ref_clk_in);
        xdone <= 8'h5A;
        ep4d <= 2'b11;
        terr <= 1'b1;
        in_empty <= 5'h16;
        @(posedge ref_clk_in);
        xdone <= 8'h00;
        ep4d <= 2'b00;
        terr <= 1'b0;
        rd(8'hBA, 8'h5A);
        chk(8'h01, {7'h00, irq_out});
        acc(1'b1, 8'hBA, 8'h0A);
        rd(8'hBA, 8'h0A);
        rd(8'hBB, 8'hBD);
        acc(1'b1, 8'hBB, 8'h00);
        rd(8'hBB, 8'hB0);
        $display("test flags done");
        acc(1'b1, 8'hBD, 8'hFF);
        rd(8'hBD, 8'h03);
        chk(8'h01, {3'h0, flush});
        @(posedge ref_clk_in);
        drained <= 5'h01;
        @(posedge ref_clk_in);
        drained <= 5'h00;
        rd(8'hBD, 8'h01);
        acc(1'b1, 8'hBE, 8'hF3);
        rd(8'hBE, 8'hF3);
        chk(8'h0F, {4'h0, zreq});
        chk(8'h10, {3'h0, dready});
        @(posedge ref_clk_in);
        zsent <= 4'h5;
        drained <= 5'h10;
        out_empty <= 5'h15;
        in_full <= 5'h0B;
        out_full <= 5'h1F;
        @(posedge ref_clk_in);
        zsent <= 4'h0;
        drained <= 5'h00;
        rd(8'hBE, 8'hA1);
        acc(1'b1, 8'h9A, 8'h03);
        rd(8'h9A, 8'hAB);
        acc(1'b1, 8'h9B, 8'h02);
        rd(8'h9B, 8'h5A);
        acc(1'b1, 8'h9C, 8'h03);
        rd(8'h9C, 8'hFB);
        $display("test buffers done");
        test_done();
    end
endmodule
